// *** rtl/wiper_port_device.sv ***
// Function
// - address pins match two slave address bits
// - write lock input is active low
// - data sampled on clock rise, MSB first
// - direction bit high reads, low writes; the device here ignores read frames
// - command bit high quick, low register; quick commands are acknowledged but change nothing here
// - target bit high store, low wiper
// - low five instruction bits are address
// - wiper addresses one and three only
// - 64-position variant ignores top two bits
// - consecutive write from one fills three next
// - host changes wipers by register writes
// - each wiper has own store slot
// - store accepts single and consecutive writes
// - twelve user store bytes, four to fifteen
// - store write starts silent programming cycle
// - host polls acknowledge after store write
// - channels numbered one and three
// - poll is start, address, write; ack when done
// - write lock blocks all writes
// - power-up midscale then restore stored values; reset sets wipers and their store slots to 8'h80 in both variants
// - programming lasts 26 ms, bus silent
//
// Local design decision: the address-and-strobe port.
`default_nettype none
module wiper_port_device #(
  parameter int PROG_CYCLES = wiper_pkg::PROG_CYCLES,
  parameter bit WIDE_256 = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_addr_select_low,
  input wire logic i_addr_select_high,
  input wire logic i_write_lock_b,
  output logic [7:0] o_wiper_chan_one,
  output logic [7:0] o_wiper_chan_three,
  output logic o_nv_busy,
  wiper_link_if.dev link
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    st_restore, st_idle, st_addr, st_addr_ack, st_instr, st_instr_ack,
    st_data, st_data_ack, st_ignore
  } dev_state_e;

  typedef struct packed {
    dev_state_e st;
    logic scl_q;
    logic sda_q;
    logic [3:0] bits;
    logic [7:0] sh;
    logic cmd;
    logic tgt;
    logic [4:0] ra;
    logic nv_pend;
    logic busy;
    logic [31:0] cnt;
    logic [7:0] w1;
    logic [7:0] w3;
    logic [wiper_pkg::NV_DEPTH-1:0][7:0] nv;
    logic sda_o;
    logic sda_oe_b;
  } dev_s;

  dev_s q_r;
  dev_s q_nxt;
  logic [4:0] sy;
  logic scl_s;
  logic sda_s;
  logic lock_b_s;
  logic [1:0] sel_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] din;
  logic nv_ok;

  // ----------------------------------------------------------------
  // pin sampling and line events
  // ----------------------------------------------------------------
  pin_sync #(.W(5)) u_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_d({link.scl, link.sda, i_write_lock_b, i_addr_select_high, i_addr_select_low}),
    .o_q(sy)
  );
  assign scl_s = sy[4];
  assign sda_s = sy[3];
  assign lock_b_s = sy[2];
  assign sel_s = sy[1:0];
  assign scl_rise = scl_s & ~q_r.scl_q;
  assign scl_fall = ~scl_s & q_r.scl_q;
  assign start_c = scl_s & q_r.scl_q & q_r.sda_q & ~sda_s;
  assign stop_c = scl_s & q_r.scl_q & ~q_r.sda_q & sda_s;
  assign din = WIDE_256 ? q_r.sh : (q_r.sh & wiper_pkg::LOW6_MASK);
  assign nv_ok = (q_r.ra == wiper_pkg::ADDR_WIPER_ONE) ||
    (q_r.ra == wiper_pkg::ADDR_WIPER_THREE) ||
    ((q_r.ra >= wiper_pkg::ADDR_USER_FIRST) && (q_r.ra <= wiper_pkg::ADDR_USER_LAST));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.scl_q = scl_s;
    q_nxt.sda_q = sda_s;
    if (q_r.busy) begin
      q_nxt.cnt = q_r.cnt + 32'h1;
      if (q_r.cnt == 32'(PROG_CYCLES - 1)) begin
        q_nxt.busy = 1'b0;
        q_nxt.cnt = '0;
      end
    end
    if (scl_rise && q_r.bits != wiper_pkg::BYTE_BITS) begin
      q_nxt.sh = {q_r.sh[6:0], sda_s};
      q_nxt.bits = q_r.bits + 4'h1;
    end
    unique case (q_r.st)
      st_restore: begin
        // midscale at reset, then stored values
        q_nxt.w1 = q_r.nv[wiper_pkg::ADDR_WIPER_ONE];
        q_nxt.w3 = q_r.nv[wiper_pkg::ADDR_WIPER_THREE];
        q_nxt.st = st_idle;
      end
      st_addr: begin
        if (scl_fall && q_r.bits == wiper_pkg::BYTE_BITS) begin
          q_nxt.bits = '0;
          // pins pick the address; only writes answered
          if (q_r.sh[7:1] == {wiper_pkg::SLAVE_BASE, sel_s} && !q_r.sh[0]) begin
            q_nxt.st = st_addr_ack;
            q_nxt.sda_oe_b = 1'b0;
          end else begin
            q_nxt.st = st_ignore;
          end
        end
      end
      st_instr: begin
        if (scl_fall && q_r.bits == wiper_pkg::BYTE_BITS) begin
          q_nxt.bits = '0;
          // command select; target select; address field
          q_nxt.cmd = q_r.sh[wiper_pkg::INSTR_CMD_BIT];
          q_nxt.tgt = q_r.sh[wiper_pkg::INSTR_TGT_BIT];
          q_nxt.ra = q_r.sh[4:0];
          q_nxt.st = st_instr_ack;
          q_nxt.sda_oe_b = 1'b0;
        end
      end
      st_data: begin
        if (scl_fall && q_r.bits == wiper_pkg::BYTE_BITS) begin
          q_nxt.bits = '0;
          q_nxt.st = st_data_ack;
          q_nxt.sda_oe_b = 1'b0;
          if (lock_b_s && !q_r.cmd) begin
            // store takes single or consecutive bytes
            if (q_r.tgt) begin
              // wiper slots share the address; reserved ignored
              if (nv_ok) begin
                q_nxt.nv[q_r.ra[3:0]] = din;
                q_nxt.nv_pend = 1'b1;
              end
            // wiper one and three; channel numbering
            end else if (q_r.ra == wiper_pkg::ADDR_WIPER_ONE) begin
              q_nxt.w1 = din;
            end else if (q_r.ra == wiper_pkg::ADDR_WIPER_THREE) begin
              q_nxt.w3 = din;
            end
          end
          q_nxt.ra = q_r.ra + (q_r.tgt ? wiper_pkg::STEP_STORE : wiper_pkg::STEP_WIPER);
        end
      end
      st_addr_ack, st_instr_ack, st_data_ack: begin
        if (scl_fall) begin
          // the acknowledge clock shifted a bit in: drop it so the next byte starts clean
          q_nxt.bits = '0;
          q_nxt.sda_oe_b = 1'b1;
          q_nxt.st = (q_r.st == st_addr_ack) ? st_instr : st_data;
        end
      end
      st_idle, st_ignore: begin
      end
    endcase
    // silent while programming; poll acked once done
    if (start_c && !q_r.busy && q_r.st != st_restore) begin
      q_nxt.st = st_addr;
      q_nxt.bits = '0;
      q_nxt.sda_oe_b = 1'b1;
    end else if (stop_c && q_r.st != st_restore) begin
      q_nxt.st = st_idle;
      q_nxt.sda_oe_b = 1'b1;
      if (q_r.nv_pend) begin
        q_nxt.nv_pend = 1'b0;
        q_nxt.busy = 1'b1;
        q_nxt.cnt = '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // store contents are only a model: reset reloads wiper slots with midscale
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q_r <= '0;
      q_r.st <= st_restore;
      q_r.scl_q <= 1'b1;
      q_r.sda_q <= 1'b1;
      q_r.sda_oe_b <= 1'b1;
      q_r.w1 <= wiper_pkg::MIDSCALE;
      q_r.w3 <= wiper_pkg::MIDSCALE;
      q_r.nv[wiper_pkg::ADDR_WIPER_ONE] <= wiper_pkg::MIDSCALE;
      q_r.nv[wiper_pkg::ADDR_WIPER_THREE] <= wiper_pkg::MIDSCALE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_wiper_chan_one = q_r.w1;
  assign o_wiper_chan_three = q_r.w3;
  assign o_nv_busy = q_r.busy;
  assign link.dev_sda = q_r.sda_o;
  assign link.dev_sda_oe_b = q_r.sda_oe_b;
endmodule
`default_nettype wire

// *** rtl/wiper_pkg.sv ***
`default_nettype none
package wiper_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int PROG_TIME_US = 26000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int SCL_HALF_NS = 1250;
  localparam int SCL_HALF_CYCLES = SCL_HALF_NS * CLK_MHZ / 1000;
  // ----------------------------------------------------------------
  // link framing
  // ----------------------------------------------------------------
  // upper slave address bits, value arbitrary
  localparam logic [4:0] SLAVE_BASE = 5'h0b;
  localparam int INSTR_CMD_BIT = 7;
  localparam int INSTR_TGT_BIT = 5;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // ----------------------------------------------------------------
  // device register and store map
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_WIPER_ONE = 5'h01;
  localparam logic [4:0] ADDR_WIPER_THREE = 5'h03;
  localparam logic [4:0] ADDR_USER_FIRST = 5'h04;
  localparam logic [4:0] ADDR_USER_LAST = 5'h0f;
  localparam logic [4:0] STEP_STORE = 5'h01;
  localparam logic [4:0] STEP_WIPER = 5'h02;
  localparam int NV_DEPTH = 16;
  localparam logic [7:0] MIDSCALE = 8'h80;
  localparam logic [7:0] LOW6_MASK = 8'h3f;
  // ----------------------------------------------------------------
  // host command registers
  // ----------------------------------------------------------------
  localparam logic [2:0] HREG_SLAVE = 3'h0;
  localparam logic [2:0] HREG_INSTR = 3'h1;
  localparam logic [2:0] HREG_DATA0 = 3'h2;
  localparam logic [2:0] HREG_DATA1 = 3'h3;
  localparam logic [2:0] HREG_GO = 3'h4;
  localparam logic [2:0] HREG_STATUS = 3'h5;
endpackage
`default_nettype wire

// *** rtl/wiper_link_if.sv ***
`default_nettype none
interface wiper_link_if;
  logic scl;
  logic sda;
  logic host_scl;
  logic host_scl_oe_b;
  logic host_sda;
  logic host_sda_oe_b;
  logic dev_sda;
  logic dev_sda_oe_b;
  // open-drain wires with pull-ups: any enabled driver wins
  assign scl = host_scl_oe_b | host_scl;
  assign sda = (host_sda_oe_b | host_sda) & (dev_sda_oe_b | dev_sda);
  modport host (input sda, output host_scl, host_scl_oe_b, host_sda, host_sda_oe_b);
  modport dev (input scl, sda, output dev_sda, dev_sda_oe_b);
endinterface
`default_nettype wire

// *** rtl/pin_sync.sv ***
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_s;
  sync_s q_r;
  sync_s q_nxt;
  always_comb begin
    q_nxt.meta = i_d;
    q_nxt.q = q_r.meta;
  end
  // idle bus level is high, so reset to ones
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q_r <= '1;
    end else begin
      q_r <= q_nxt;
    end
  end
  assign o_q = q_r.q;
endmodule
`default_nettype wire

// *** rtl/wiper_host.sv ***
`default_nettype none
module wiper_host (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  wiper_link_if.host link
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {h_idle, h_start, h_low, h_high, h_stop, h_stop2} host_state_e;

  typedef struct packed {
    host_state_e st;
    logic [15:0] cnt;
    logic scl_oe_b;
    logic sda_o;
    logic sda_oe_b;
    logic [7:0] sh;
    logic [3:0] bits;
    logic [1:0] sent;
    logic [1:0] count;
    logic [6:0] slave;
    logic [7:0] instr;
    logic [7:0] d0;
    logic [7:0] d1;
    logic nack;
    logic [7:0] rdata;
  } host_s;

  host_s q_r;
  host_s q_nxt;
  logic sda_s;
  logic tick;
  logic [7:0] next_byte;

  pin_sync #(.W(1)) u_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_d(link.sda),
    .o_q(sda_s)
  );

  assign tick = (q_r.cnt == 16'(wiper_pkg::SCL_HALF_CYCLES - 1));
  always_comb begin
    unique case (q_r.sent)
      2'h0: next_byte = q_r.instr;
      2'h1: next_byte = q_r.d0;
      default: next_byte = q_r.d1;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.cnt = (q_r.st == h_idle || tick) ? 16'h0 : q_r.cnt + 16'h1;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        wiper_pkg::HREG_SLAVE: q_nxt.rdata = {1'b0, q_r.slave};
        wiper_pkg::HREG_INSTR: q_nxt.rdata = q_r.instr;
        wiper_pkg::HREG_DATA0: q_nxt.rdata = q_r.d0;
        wiper_pkg::HREG_DATA1: q_nxt.rdata = q_r.d1;
        wiper_pkg::HREG_GO: q_nxt.rdata = {6'h0, q_r.count};
        wiper_pkg::HREG_STATUS: q_nxt.rdata = {6'h0, q_r.nack, q_r.st != h_idle};
        default: q_nxt.rdata = 8'h0;
      endcase
    end
    // settings are frozen while a transfer runs
    if (i_reg_wr && q_r.st == h_idle) begin
      unique case (i_reg_addr)
        wiper_pkg::HREG_SLAVE: q_nxt.slave = i_reg_wdata[6:0];
        wiper_pkg::HREG_INSTR: q_nxt.instr = i_reg_wdata;
        wiper_pkg::HREG_DATA0: q_nxt.d0 = i_reg_wdata;
        wiper_pkg::HREG_DATA1: q_nxt.d1 = i_reg_wdata;
        wiper_pkg::HREG_GO: begin
          q_nxt.count = i_reg_wdata[1:0];
          q_nxt.sh = {q_r.slave, 1'b0};
          q_nxt.bits = '0;
          q_nxt.sent = '0;
          q_nxt.nack = 1'b0;
          q_nxt.sda_oe_b = 1'b0;
          q_nxt.st = h_start;
        end
        default: begin
        end
      endcase
    end
    if (tick) begin
      unique case (q_r.st)
        h_start: begin
          q_nxt.scl_oe_b = 1'b0;
          q_nxt.sda_oe_b = q_r.sh[7];
          q_nxt.st = h_low;
        end
        h_low: begin
          q_nxt.scl_oe_b = 1'b1;
          q_nxt.st = h_high;
        end
        h_high: begin
          q_nxt.scl_oe_b = 1'b0;
          q_nxt.st = h_low;
          if (q_r.bits == wiper_pkg::BYTE_BITS) begin
            // a poll is a bare address; no ack means busy
            q_nxt.nack = sda_s;
            if (sda_s || q_r.sent == q_r.count) begin
              q_nxt.sda_oe_b = 1'b0;
              q_nxt.st = h_stop;
            end else begin
              // instruction then wiper or store data
              q_nxt.sh = next_byte;
              q_nxt.sda_oe_b = next_byte[7];
              q_nxt.sent = q_r.sent + 2'h1;
              q_nxt.bits = '0;
            end
          end else begin
            q_nxt.bits = q_r.bits + 4'h1;
            q_nxt.sh = {q_r.sh[6:0], 1'b0};
            // release the line for the acknowledge slot
            q_nxt.sda_oe_b = (q_r.bits == wiper_pkg::BYTE_BITS - 4'h1) ? 1'b1 : q_r.sh[6];
          end
        end
        h_stop: begin
          q_nxt.scl_oe_b = 1'b1;
          q_nxt.st = h_stop2;
        end
        h_stop2: begin
          q_nxt.sda_oe_b = 1'b1;
          q_nxt.st = h_idle;
        end
        h_idle: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q_r <= '0;
      q_r.st <= h_idle;
      q_r.scl_oe_b <= 1'b1;
      q_r.sda_oe_b <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_reg_rdata = q_r.rdata;
  assign link.host_scl = 1'b0;
  assign link.host_scl_oe_b = q_r.scl_oe_b;
  assign link.host_sda = q_r.sda_o;
  assign link.host_sda_oe_b = q_r.sda_oe_b;
endmodule
`default_nettype wire

// *** testbench/wiper_link_sva.sv ***
`default_nettype none
module wiper_link_sva #(
  parameter int PROG_CYCLES = 200
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe_b,
  input wire logic i_write_lock_b,
  input wire logic [7:0] o_wiper_chan_one,
  input wire logic [7:0] o_wiper_chan_three,
  input wire logic o_nv_busy
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic [3:0] lock_cnt_r;
  logic [31:0] busy_cnt_r;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lock_cnt_r <= 4'h0;
      busy_cnt_r <= 32'h0;
    end else begin
      if (i_write_lock_b) begin
        lock_cnt_r <= 4'h0;
      end else if (lock_cnt_r != 4'hf) begin
        lock_cnt_r <= lock_cnt_r + 4'h1;
      end
      busy_cnt_r <= o_nv_busy ? busy_cnt_r + 32'h1 : 32'h0;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  a_ack_near_fall: assert property (
    $fell(dev_sda_oe_b) |-> !scl && $past(scl, 8)) else $error("ack not after scl fall");
  a_ack_holds: assert property (
    $rose(scl) && !dev_sda_oe_b |=> !dev_sda_oe_b [*8]) else $error("ack dropped in high");
  a_ack_release: assert property (
    $fell(dev_sda_oe_b) |-> ##[480:520] $rose(dev_sda_oe_b)) else $error("ack length wrong");
  a_busy_no_ack: assert property (
    o_nv_busy |-> dev_sda_oe_b) else $error("device answered while busy");
  a_busy_idle_bus: assert property (
    $rose(o_nv_busy) |-> scl && sda) else $error("programming began mid frame");
  a_busy_length: assert property (
    $fell(o_nv_busy) |-> busy_cnt_r >= 32'(PROG_CYCLES - 4) &&
    busy_cnt_r <= 32'(PROG_CYCLES + 4)) else $error("programming length wrong");
  a_lock_no_change: assert property (
    lock_cnt_r == 4'hf |-> $stable(o_wiper_chan_one) && $stable(o_wiper_chan_three))
    else $error("wiper changed under lock");
  a_wiper_reset: assert property (
    $rose(i_rst_b) |-> o_wiper_chan_one == wiper_pkg::MIDSCALE &&
    o_wiper_chan_three == wiper_pkg::MIDSCALE) else $error("wiper not midscale");
  c_ack: cover property ($fell(dev_sda_oe_b));
  c_busy: cover property ($rose(o_nv_busy));
  c_wiper: cover property ($changed(o_wiper_chan_three));
endmodule
`default_nettype wire

// *** testbench/dual_wiper_i2c_register_port_bench.sv ***
`default_nettype none
module dual_wiper_i2c_register_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // short programming cycle keeps the run brief but outlasts one poll
  localparam int PROG = 6000;
  logic i_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b0;
  logic lock_b = 1'b1;
  logic [7:0] one, three;
  logic nv_busy;
  logic rd_q = 1'b0, chk_q = 1'b0, chk_nx = 1'b0, scl_p = 1'b1, sda_p = 1'b1;
  logic [7:0] rq[$];
  logic [7:0] last_rd, exp_first, sh, d0, d1, d2;
  logic [6:0] dev_addr;
  int errors = 0, total_checks = 0, nb = 8, seed;
  wiper_link_if link_if();
  wiper_host i_wiper_host (.i_clk(i_clk), .i_rst_b(rst_b), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .link(link_if));
  wiper_port_device #(.PROG_CYCLES(PROG), .WIDE_256(1'b1)) i_wiper_port_device (
    .i_clk(i_clk), .i_rst_b(rst_b), .i_addr_select_low(sel_lo),
    .i_addr_select_high(sel_hi), .i_write_lock_b(lock_b), .o_wiper_chan_one(one),
    .o_wiper_chan_three(three), .o_nv_busy(nv_busy), .link(link_if));
  wiper_link_sva #(.PROG_CYCLES(PROG)) i_wiper_link_sva (.i_clk(i_clk), .i_rst_b(rst_b),
    .scl(link_if.scl), .sda(link_if.sda), .dev_sda_oe_b(link_if.dev_sda_oe_b),
    .i_write_lock_b(lock_b), .o_wiper_chan_one(one), .o_wiper_chan_three(three),
    .o_nv_busy(nv_busy));
  logic [7:0] one_n, three_n;
  wiper_link_if link_n_if();
  // twin pair of the 64-position variant runs the same frames in parallel
  wiper_host i_wiper_host_narrow (.i_clk(i_clk), .i_rst_b(rst_b), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(), .link(link_n_if));
  wiper_port_device #(.PROG_CYCLES(PROG), .WIDE_256(1'b0)) i_wiper_port_device_narrow (
    .i_clk(i_clk), .i_rst_b(rst_b), .i_addr_select_low(sel_lo),
    .i_addr_select_high(sel_hi), .i_write_lock_b(lock_b), .o_wiper_chan_one(one_n),
    .o_wiper_chan_three(three_n), .o_nv_busy(), .link(link_n_if));
  always #2.5 i_clk = ~i_clk;
  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic cmp_val(input string name, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic reg_wr_t(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge i_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_rd_t(input logic [2:0] a, input logic chk, input logic [7:0] e);
    @(posedge i_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    chk_nx <= chk;
    if (chk) rq.push_back(e);
    @(posedge i_clk);
    reg_rd <= 1'b0;
    @(negedge i_clk);
    last_rd = reg_rdata;
  endtask
  // one whole frame; the final status read carries the expected acknowledge
  task automatic xfer(input logic [6:0] sa, input logic [7:0] ins, input logic [7:0] a,
      input logic [7:0] b, input logic [1:0] n, input logic nack);
    exp_first = {sa, 1'b0};
    reg_wr_t(wiper_pkg::HREG_SLAVE, {1'b0, sa});
    reg_wr_t(wiper_pkg::HREG_INSTR, ins);
    reg_wr_t(wiper_pkg::HREG_DATA0, a);
    reg_wr_t(wiper_pkg::HREG_DATA1, b);
    reg_wr_t(wiper_pkg::HREG_GO, {6'h00, n});
    repeat (4) @(posedge i_clk);
    for (int k = 0; k < 20000; k++) begin
      reg_rd_t(wiper_pkg::HREG_STATUS, 1'b0, 8'h00);
      if (last_rd[0] === 1'b0) break;
    end
    reg_rd_t(wiper_pkg::HREG_STATUS, 1'b1, {6'h00, nack, 1'b0});
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // result watchers
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    rd_q <= reg_rd;
    chk_q <= chk_nx;
  end
  always @(negedge i_clk) begin
    if (rd_q && chk_q && rq.size() > 0) cmp_val("status", rq.pop_front(), reg_rdata);
  end
  // first byte of each frame as it appears on the wire
  always @(posedge i_clk) begin
    scl_p <= link_if.scl;
    sda_p <= link_if.sda;
    if (link_if.scl === 1'b1 && scl_p && sda_p && link_if.sda === 1'b0) begin
      nb = 0;
    end else if (link_if.scl === 1'b1 && scl_p === 1'b0 && nb < 8) begin
      sh = {sh[6:0], link_if.sda};
      nb++;
      if (nb == 8) cmp_val("first byte", exp_first, sh);
    end
  end
  initial begin
    repeat (100000) @(posedge i_clk);
    errors++;
    $display("ERROR watchdog expected done seen timeout");
    finish_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 69323;
    dev_addr = {wiper_pkg::SLAVE_BASE, 2'($random(seed))};
    sel_lo <= dev_addr[0];
    sel_hi <= dev_addr[1];
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    repeat (6) @(posedge i_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    cmp_val("wiper one", wiper_pkg::MIDSCALE, one);
    xfer(dev_addr, 8'h01, d0, d1, 2'h3, 1'b0);
    cmp_val("wiper one", d0, one);
    cmp_val("wiper three", d1, three);
    cmp_val("narrow one", d0 & wiper_pkg::LOW6_MASK, one_n);
    cmp_val("narrow three", d1 & wiper_pkg::LOW6_MASK, three_n);
    xfer(dev_addr, 8'h03, d2, 8'h00, 2'h2, 1'b0);
    cmp_val("wiper three", d2, three);
    cmp_val("narrow three", d2 & wiper_pkg::LOW6_MASK, three_n);
    xfer(dev_addr, 8'h02, ~d0, 8'h00, 2'h2, 1'b0);
    cmp_val("wiper one", d0, one);
    cmp_val("wiper three", d2, three);
    xfer(dev_addr ^ 7'h01, 8'h01, ~d0, 8'h00, 2'h2, 1'b1);
    cmp_val("wiper one", d0, one);
    xfer(dev_addr, 8'h24, d1, d2, 2'h3, 1'b0);
    repeat (8) @(posedge i_clk);
    cmp_val("store busy", 8'h01, {7'h00, nv_busy});
    cmp_val("wiper one", d0, one);
    xfer(dev_addr, 8'h00, 8'h00, 8'h00, 2'h0, 1'b1);
    for (int k = 0; k < 2 * PROG && nv_busy !== 1'b0; k++) @(posedge i_clk);
    @(posedge i_clk);
    lock_b <= 1'b0;
    repeat (4) @(posedge i_clk);
    xfer(dev_addr, 8'h01, ~d0, 8'h00, 2'h2, 1'b0);
    cmp_val("wiper one", d0, one);
    lock_b <= 1'b1;
    finish_test();
  end
endmodule
`default_nettype wire
